//--- sync_serial_pkg.sv
// Purpose: constants for the synchronous serial shift port
// Assumes: 8-bit register port, one 10 MHz clock
// Notes: addresses are full 16-bit values, decoded on all 16 bits
package sync_serial_pkg;
  localparam logic [15:0] SERIAL_CONTROL_ADDR        = 16'hFFA0;
  localparam logic [15:0] SERIAL_CONTROL_STATUS_ADDR = 16'hFFA1;
  localparam logic [15:0] SERIAL_DATA_UPPER_ADDR     = 16'hFFA2;
  localparam logic [15:0] SERIAL_DATA_LOWER_ADDR     = 16'hFFA3;
  localparam logic [7:0]  SERIAL_CONTROL_RESET       = 8'h00;
  localparam logic [7:0]  SERIAL_STATUS_RESET        = 8'h80;
  localparam int          MODE_HI_BIT                = 7;
  localparam int          MODE_LO_BIT                = 6;
  localparam int          CLOCK_SOURCE_BIT           = 3;
  localparam int          TX_LEVEL_BIT               = 6;
  localparam int          OVERRUN_BIT                = 5;
  localparam int          START_BIT                  = 0;
  localparam logic [1:0]  MODE_8BIT                  = 2'h0;
  localparam logic [1:0]  MODE_16BIT                 = 2'h1;
  localparam logic [1:0]  MODE_CLOCK_OUT             = 2'h2;
  localparam int          DIV_WIDTH                  = 10;
endpackage : sync_serial_pkg

//--- serial_prescaler.sv
// Purpose: free running divider giving serial clock half-period enables
// Assumes: synchronous reset
// Notes: half-period pulse at twice the selected serial rate
`timescale 1ns/1ns
`default_nettype none
module serial_prescaler
  import sync_serial_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic [2:0] div_sel,
  output logic            half_tick
);
  logic [DIV_WIDTH-1:0] count;

  function automatic logic [DIV_WIDTH-1:0] half_mask(input logic [2:0] sel);
    unique case (sel)
      3'h0:    half_mask = 10'h1FF;
      3'h1:    half_mask = 10'h07F;
      3'h2:    half_mask = 10'h01F;
      3'h3:    half_mask = 10'h00F;
      3'h4:    half_mask = 10'h007;
      3'h5:    half_mask = 10'h003;
      3'h6:    half_mask = 10'h001;
      default: half_mask = 10'h000;
    endcase
  endfunction : half_mask

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      count <= '0;
    else
      count <= count + 10'h001;
  end

  always_comb
  begin
    half_tick = ((count & half_mask(div_sel)) == half_mask(div_sel));
  end
endmodule : serial_prescaler
`default_nettype wire

//--- sync_serial_shift_port.sv
// Purpose: synchronous serial shift channel with register port
// Assumes: pins synchronous to ref_clk; external clock slow versus ref_clk
// Notes: read data valid one cycle after read strobe
`timescale 1ns/1ns
`default_nettype none
module sync_serial_shift_port
  import sync_serial_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [7:0]       reg_rdata,
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe,
  input  wire logic        serial_rx_pin,
  output logic             serial_tx_pin,
  output logic             data_pins_in_use,
  output logic             transfer_irq
);
  import sync_serial_pkg::*;

  typedef enum logic [1:0] {IDLE, WAIT_CLK, SHIFT} state_e;

  state_e      state;
  logic [7:0]  serial_control;
  logic [7:0]  serial_data_upper;
  logic [7:0]  serial_data_lower;
  logic        overrun_flag;
  logic        overrun_seen;
  logic [4:0]  bit_count;
  logic        ext_clk_d;
  logic        half_tick;
  logic        rise_ev;
  logic        fall_ev;
  logic        int_clk;
  logic        next_int_clk;
  logic [1:0]  op_mode;
  logic        ext_src;
  logic        sel_ctrl;
  logic        sel_stat;
  logic        sel_upper;
  logic        sel_lower;
  logic        busy;
  logic        done;
  logic [4:0]  last_bit;

  assign op_mode   = serial_control[MODE_HI_BIT:MODE_LO_BIT];
  assign ext_src   = serial_control[CLOCK_SOURCE_BIT];
  assign sel_ctrl  = (reg_addr == SERIAL_CONTROL_ADDR);
  assign sel_stat  = (reg_addr == SERIAL_CONTROL_STATUS_ADDR);
  assign sel_upper = (reg_addr == SERIAL_DATA_UPPER_ADDR);
  assign sel_lower = (reg_addr == SERIAL_DATA_LOWER_ADDR);
  assign busy      = (state != IDLE);
  assign last_bit  = (op_mode == MODE_16BIT) ? 5'h0F : 5'h07;

  serial_prescaler u_prescaler (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .div_sel   (serial_control[2:0]),
    .half_tick (half_tick)
  );

  always_comb
  begin
    if (ext_src)
    begin
      rise_ev = serial_clock_pin_in & ~ext_clk_d;
      fall_ev = ~serial_clock_pin_in & ext_clk_d;
    end
    else
    begin
      rise_ev = half_tick & ~int_clk & (state == SHIFT);
      fall_ev = half_tick & int_clk & (state == SHIFT);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      ext_clk_d <= 1'b1;
    else
      ext_clk_d <= serial_clock_pin_in;
  end

  // Internal clock idles high; the first fall begins bit 0
  always_comb
  begin
    next_int_clk = int_clk;
    if (op_mode == MODE_CLOCK_OUT || state == SHIFT)
    begin
      if (half_tick)
        next_int_clk = ~int_clk;
    end
    else
      next_int_clk = 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      int_clk <= 1'b1;
    else
      int_clk <= next_int_clk;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      serial_control <= SERIAL_CONTROL_RESET;
    else if (reg_write && sel_ctrl)
      serial_control <= reg_wdata;
  end

  assign done = (state == SHIFT) && rise_ev && (bit_count == last_bit);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      state <= IDLE;
    else if (reg_write && sel_ctrl)
      state <= IDLE;
    else
      unique case (state)
        IDLE:
          if (reg_write && sel_stat && reg_wdata[START_BIT] && op_mode != MODE_CLOCK_OUT)
            state <= ext_src ? WAIT_CLK : SHIFT;
        WAIT_CLK:
          if (fall_ev)
            state <= SHIFT;
        SHIFT:
          if (done)
            state <= IDLE;
      endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      bit_count <= 5'h00;
    else if (state != SHIFT)
      bit_count <= 5'h00;
    else if (rise_ev)
      bit_count <= bit_count + 5'h01;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reg_write && sel_lower && !busy)
      serial_data_lower <= reg_wdata;
    else if (state == SHIFT && rise_ev)
    begin
      if (op_mode == MODE_16BIT)
        serial_data_lower <= {serial_data_upper[0], serial_data_lower[7:1]};
      else
        serial_data_lower <= {serial_rx_pin, serial_data_lower[7:1]};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reg_write && sel_upper && !busy)
      serial_data_upper <= reg_wdata;
    else if (state == SHIFT && rise_ev && op_mode == MODE_16BIT)
      serial_data_upper <= {serial_rx_pin, serial_data_upper[7:1]};
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      serial_tx_pin <= 1'b0;
    else if (reg_write && sel_stat && !busy)
      serial_tx_pin <= reg_wdata[TX_LEVEL_BIT];
    else if (busy && fall_ev)
      serial_tx_pin <= serial_data_lower[0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      overrun_flag <= 1'b0;
      overrun_seen <= 1'b0;
    end
    else
    begin
      if (reg_read && sel_stat)
        overrun_seen <= overrun_flag;
      if (ext_src && state == IDLE && fall_ev && op_mode != MODE_CLOCK_OUT)
        overrun_flag <= 1'b1;
      else if (reg_write && sel_stat && !reg_wdata[OVERRUN_BIT] && overrun_seen)
      begin
        overrun_flag <= 1'b0;
        overrun_seen <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      transfer_irq <= 1'b0;
    else
      // A control write in the completing cycle still counts as an abort
      transfer_irq <= done && !(reg_write && sel_ctrl);
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      serial_clock_pin_out <= 1'b1;
      serial_clock_pin_oe  <= 1'b1;
    end
    else
    begin
      // Pin moves on the same edge as tx and rx sampling, so even /2 keeps the phases
      serial_clock_pin_out <= next_int_clk;
      serial_clock_pin_oe  <= ~ext_src;
    end
  end

  // data pins free in clock-out mode
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      data_pins_in_use <= 1'b1;
    else
      data_pins_in_use <= (op_mode != MODE_CLOCK_OUT);
  end

  // status readback, bit 7 reads one
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_read)
    begin
      if (sel_ctrl)
        reg_rdata <= serial_control;
      else if (sel_stat)
        reg_rdata <= SERIAL_STATUS_RESET | {1'b0, serial_tx_pin, overrun_flag, 4'h0, busy};
      else if (sel_upper)
        reg_rdata <= serial_data_upper;
      else if (sel_lower)
        reg_rdata <= serial_data_lower;
      else
        reg_rdata <= 8'h00;
    end
    else
      reg_rdata <= 8'h00;
  end
endmodule : sync_serial_shift_port
`default_nettype wire

//--- sync_serial_checker.sv
// Purpose: port checks for the serial shift port
// Assumes: a shadow copy tracks control writes
// Notes: pin, control readback and clock-run checks wait for the registered outputs to settle after a control write
`timescale 1ns/1ns
`default_nettype none
module sync_serial_checker
  import sync_serial_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic        serial_clock_pin_out,
  input wire logic        serial_clock_pin_oe,
  input wire logic        data_pins_in_use,
  input wire logic        transfer_irq
);
  logic [7:0] ctl;
  logic [1:0] age;
  wire        ctl_wr = reg_write && reg_addr == SERIAL_CONTROL_ADDR;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  always_ff @(posedge ref_clk)
  begin
    ctl <= srst ? SERIAL_CONTROL_RESET : (ctl_wr ? reg_wdata : ctl);
    age <= srst ? 2'h3 : (ctl_wr ? 2'h0 : (age == 2'h3 ? age : age + 2'h1));
  end
  sequence ctl_write_s;
    ctl_wr;
  endsequence
  pin_dir_a: assert property (age > 2'h1 |-> serial_clock_pin_oe == !ctl[CLOCK_SOURCE_BIT])
    else $error("clock pin direction wrong");
  data_pins_a: assert property (age > 2'h1 |-> data_pins_in_use == (ctl[7:6] != MODE_CLOCK_OUT))
    else $error("data pin use wrong");
  ctl_read_a: assert property ($past(reg_read && reg_addr == SERIAL_CONTROL_ADDR) && age > 2'h2 |-> reg_rdata == ctl)
    else $error("control readback wrong");
  status_fix_a: assert property ($past(reg_read && reg_addr == SERIAL_CONTROL_STATUS_ADDR) |-> reg_rdata[7] && reg_rdata[4:1] == 4'h0)
    else $error("status fixed bits wrong");
  irq_pulse_a: assert property (transfer_irq |=> !transfer_irq)
    else $error("irq longer than one cycle");
  abort_a: assert property (ctl_write_s |=> ##1 !transfer_irq [*4])
    else $error("irq after abort");
  irq_mode_a: assert property (transfer_irq |-> data_pins_in_use)
    else $error("irq in clock-out mode");
  clk_run_a: assert property (age > 2'h2 && ctl[7:6] == MODE_CLOCK_OUT |-> ##[1:520] $changed(serial_clock_pin_out))
    else $error("clock output stalled");
endmodule : sync_serial_checker
bind sync_serial_shift_port sync_serial_checker chk_i (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .serial_clock_pin_out, .serial_clock_pin_oe, .data_pins_in_use, .transfer_irq);
`default_nettype wire

//--- serial_peer_model.sv
// Purpose: far-side serial device
// Assumes: clock level synchronous to ref_clk
// Notes: rx is set to a non-data level on load, before the first fall
`timescale 1ns/1ns
`default_nettype none
module serial_peer_model
(
  input  wire logic        ref_clk,
  input  wire logic        sck,
  input  wire logic        tx,
  input  wire logic        load,
  input  wire logic [15:0] send_word,
  output logic             rx,
  output logic [15:0]      got_word
);
  logic        sck_q;
  logic [15:0] sr;
  always_ff @(posedge ref_clk)
  begin
    sck_q <= sck;
    if (load)
    begin
      sr <= send_word;
      rx <= ~send_word[15];
    end
    else if (sck_q && !sck)
    begin
      rx <= sr[0];
      sr <= sr >> 1;
    end
    if (!sck_q && sck)
      got_word <= {tx, got_word[15:1]};
  end
endmodule : serial_peer_model
`default_nettype wire

//--- sync_serial_shift_port_test.sv
// Purpose: self-checking bench for the serial shift port
// Assumes: one-cycle register strobes
// Notes: divide by 4 keeps the peer and port off the same edge
`timescale 1ns/1ns
`default_nettype none
module sync_serial_shift_port_test;
  import sync_serial_pkg::*;
  logic        ref_clk = 1'b0, srst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, ck_in = 1'b1, load = 1'b0;
  logic [15:0] reg_addr = 16'h0000, send = 16'h0000, got;
  logic [7:0]  reg_wdata = 8'h00, rdata, d;
  logic        ck_out, ck_oe, rx, tx, in_use, irq;
  wire logic   sck = ck_oe ? ck_out : ck_in;
  int          err_count = 0, checks = 0, irqs = 0, k;
  logic [31:0] seed = 32'd87590;
  sync_serial_shift_port dut (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata(rdata),
    .serial_clock_pin_in(ck_in), .serial_clock_pin_out(ck_out), .serial_clock_pin_oe(ck_oe),
    .serial_rx_pin(rx), .serial_tx_pin(tx), .data_pins_in_use(in_use), .transfer_irq(irq));
  serial_peer_model peer (.ref_clk, .sck, .tx, .load, .send_word(send), .rx, .got_word(got));
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (irq === 1'b1) irqs++;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(posedge ref_clk);
    d = rdata;
  endtask : rd
  task automatic pulses(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge ref_clk);
      ck_in <= 1'b0;
      repeat (4) @(posedge ref_clk);
      ck_in <= 1'b1;
    end
  endtask : pulses
  task automatic xfer(input logic [7:0] c, input bit ext);
    logic [15:0] w;
    int          n;
    seed = lfsr(seed);
    w    = seed[15:0];
    n    = c[6] ? 16 : 8;
    k    = irqs;
    wr(SERIAL_CONTROL_ADDR, c);
    wr(SERIAL_DATA_UPPER_ADDR, w[15:8]);
    wr(SERIAL_DATA_LOWER_ADDR, w[7:0]);
    seed = lfsr(seed);
    send <= seed[15:0];
    load <= 1'b1;
    @(posedge ref_clk);
    load <= 1'b0;
    wr(SERIAL_CONTROL_STATUS_ADDR, 8'h01);
    rd(SERIAL_CONTROL_STATUS_ADDR);
    chk(d & 8'h01, 8'h01);
    if (ext) pulses(n);
    for (int i = 0; i < 300 && irqs == k; i++) @(posedge ref_clk);
    chk(8'(irqs), 8'(k + 1));
    rd(SERIAL_CONTROL_STATUS_ADDR);
    chk(d & 8'h01, 8'h00);
    chk(got[15:8], n == 16 ? w[15:8] : w[7:0]);
    if (n == 16) chk(got[7:0], w[7:0]);
    rd(SERIAL_DATA_LOWER_ADDR);
    chk(d, send[7:0]);
    rd(SERIAL_DATA_UPPER_ADDR);
    if (n == 16) chk(d, send[15:8]);
  endtask : xfer
  task automatic half_period(input logic [7:0] c, input int e);
    logic p;
    int   n;
    wr(SERIAL_CONTROL_ADDR, c);
    repeat (4) @(posedge ref_clk);
    p = ck_out;
    while (ck_out === p) @(posedge ref_clk);
    p = ck_out;
    n = 0;
    while (ck_out === p && n < 1000)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk(8'(n), 8'(e));
  endtask : half_period
  task automatic complete_run;
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    rd(SERIAL_CONTROL_ADDR);
    chk(d, SERIAL_CONTROL_RESET);
    rd(SERIAL_CONTROL_STATUS_ADDR);
    chk(d, SERIAL_STATUS_RESET);
    rd(16'hFFA4);
    chk(d, 8'h00);
    wr(SERIAL_CONTROL_ADDR, 8'h36);
    rd(SERIAL_CONTROL_ADDR);
    chk(d, 8'h36);
    xfer(8'h36, 1'b0);
    xfer(8'h76, 1'b0);
    xfer(8'h0E, 1'b1);
    chk(8'(ck_oe), 8'h00);
    pulses(1);
    rd(SERIAL_CONTROL_STATUS_ADDR);
    chk(d & 8'h20, 8'h20);
    wr(SERIAL_CONTROL_STATUS_ADDR, 8'h00);
    rd(SERIAL_CONTROL_STATUS_ADDR);
    chk(d & 8'h20, 8'h00);
    wr(SERIAL_CONTROL_STATUS_ADDR, 8'h40);
    rd(SERIAL_CONTROL_STATUS_ADDR);
    chk(d & 8'h41, 8'h40);
    chk(8'(tx), 8'h01);
    wr(SERIAL_CONTROL_ADDR, 8'h36);
    wr(SERIAL_CONTROL_STATUS_ADDR, 8'h01);
    repeat (6) @(posedge ref_clk);
    k = irqs;
    wr(SERIAL_CONTROL_ADDR, 8'h36);
    rd(SERIAL_CONTROL_STATUS_ADDR);
    chk(d & 8'h01, 8'h00);
    repeat (60) @(posedge ref_clk);
    chk(8'(irqs), 8'(k));
    wr(SERIAL_CONTROL_ADDR, 8'h86);
    repeat (40) @(posedge ref_clk);
    chk(8'(in_use), 8'h00);
    half_period(8'h81, 128);
    half_period(8'h84, 8);
    half_period(8'h87, 1);
    complete_run();
  end
endmodule : sync_serial_shift_port_test
`default_nettype wire
